// ---- core/adc_conversion_control.sv ----
// Digital control of a 10-bit successive approximation converter:
// register slave, settling delay, bit search and result registers.
// Assumes an analog front end with a sample/hold switch, a 10-bit DAC
// and a comparator whose output is asynchronous to clk_i.
`timescale 1ns/100ps
`include "adc_ctrl_params.svh"

// Functional notes
// - Convert input to 10-bit scaled result
// - Out-of-range input gives all zeros/ones
// - Writing start bit begins a conversion
// - Start while busy restarts conversion
// - Start bit reads back busy status
// - Settle clocks between sample and start
// - Settle resets ones, upper bits zero
// - High result holds until next completion
// - Low result bits in bits 7:6
// - High read latches low bits
module adc_conversion_control (
  input  wire logic                 clk_i,             // System clock, 20 MHz
  input  wire logic                 reset_n_i,         // Async reset, active low
  input  wire logic [`ADDR_W-1:0]   avs_address_i,     // Byte address
  input  wire logic                 avs_read_i,        // Read request
  input  wire logic                 avs_write_i,       // Write request
  input  wire logic [`DATA_W-1:0]   avs_writedata_i,   // Write data
  input  wire logic [3:0]           avs_byteenable_i,  // Byte lanes
  output logic      [`DATA_W-1:0]   avs_readdata_o,    // Read data
  output logic                      avs_waitrequest_o, // Stall request
  input  wire logic                 cmp_i,             // Comparator, input above DAC
  output logic                      sample_hold_o,     // High while sampling
  output logic                      conv_start_o,      // Conversion start pulse
  output adc_ctrl_pkg::result_t     dac_code_o,        // Trial code to DAC
  output logic      [`CHAN_W-1:0]   analog_input_channel_o, // Input select
  output logic                      irq_o              // Interrupt, active high
);

  import adc_ctrl_pkg::*;

  // Bus handshake and decode
  logic                   wait_r;
  logic [`DATA_W-1:0]     rdata_r;
  wire                    req      = avs_read_i | avs_write_i;
  wire                    rd_acc   = avs_read_i & ~wait_r;
  wire                    wr_acc   = avs_write_i & ~wait_r & avs_byteenable_i[0];
  wire [7:0]              wbyte    = avs_writedata_i[7:0];

  wire hit_ctrl   = avs_address_i == {`ADC_CTRL_IDX, 2'b00};
  wire hit_high   = avs_address_i == {`RESULT_HIGH_IDX, 2'b00};
  wire hit_low    = avs_address_i == {`RESULT_LOW_IDX, 2'b00};
  wire hit_settle = avs_address_i == {`SETTLE_TIME_IDX, 2'b00};
  wire hit_status = avs_address_i == {`IRQ_STATUS_IDX, 2'b00};
  wire hit_mask   = avs_address_i == {`IRQ_MASK_IDX, 2'b00};

  // Software state
  logic [`CHAN_W-1:0]     chan_r;
  logic [`SETTLE_W-1:0]   settle_clocks_r;
  logic [`IRQ_W-1:0]      irq_mask_r;
  logic [`IRQ_W-1:0]      irq_status;
  logic [7:0]             result_upper_byte_r;
  logic [1:0]             latest_low_r;
  logic [1:0]             result_lower_bits_r;

  // Conversion state
  conv_state_t            state_r;
  conv_state_t            state_nxt;
  logic [`SETTLE_W-1:0]   settle_cnt_r;
  logic [`SETTLE_W-1:0]   settle_cnt_nxt;
  result_t                sar_r;
  result_t                sar_nxt;
  logic [`BIT_IDX_W-1:0]  bit_r;
  logic [`BIT_IDX_W-1:0]  bit_nxt;
  logic [1:0]             wait_cnt_r;
  logic [1:0]             wait_cnt_nxt;
  logic                   hold_nxt;
  logic                   start_nxt;
  logic                   done_evt;
  logic                   cmp_sync;

  wire busy = state_r != ST_IDLE;

  wire start_req = wr_acc & hit_ctrl & wbyte[`CTRL_START_BIT];

  wire abort_evt = start_req & busy;

  wire [`IRQ_W-1:0] irq_set;
  wire [`IRQ_W-1:0] irq_clr;

  assign irq_set[`IRQ_DONE_BIT]  = done_evt;
  assign irq_set[`IRQ_ABORT_BIT] = abort_evt;
  assign irq_clr = (wr_acc & hit_status) ? wbyte[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

  // Read data selection; unmapped addresses read zero
  wire [7:0] ctrl_rd   = {busy, 4'h0, chan_r};
  wire [7:0] settle_rd = {4'h0, settle_clocks_r};
  // Low bits in 7:6, rest zero
  wire [7:0] low_rd    = {result_lower_bits_r, 6'h00};
  wire [7:0] rd_byte   = hit_ctrl   ? ctrl_rd :
                         hit_high   ? result_upper_byte_r :
                         hit_low    ? low_rd :
                         hit_settle ? settle_rd :
                         hit_status ? {6'h00, irq_status} :
                         hit_mask   ? {6'h00, irq_mask_r} : 8'h00;

  // Comparator comes from the analog domain
  sync2 u_cmp_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (cmp_i),
    .q_o       (cmp_sync)
  );

  // One sticky flag per event
  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_W; gi++) begin : g_flag
      irq_flag u_flag (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .set_i     (irq_set[gi]),
        .clr_i     (irq_clr[gi]),
        .flag_o    (irq_status[gi])
      );
    end
  endgenerate

  // One wait state per access; data ready when waitrequest drops
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~(req & wait_r);
    end
  end

  // Read data is captured while the request waits
  wire [`DATA_W-1:0] rd_word = {24'h00_0000, rd_byte};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rd_word;
    end
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o    = rdata_r;

  // Software-written registers
  wire wr_ctrl   = wr_acc & hit_ctrl;
  wire wr_settle = wr_acc & hit_settle;
  wire wr_mask   = wr_acc & hit_mask;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chan_r <= {`CHAN_W{1'b0}};
    end else if (wr_ctrl) begin
      chan_r <= wbyte[`CHAN_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle_clocks_r <= `SETTLE_RESET;
    end else if (wr_settle) begin
      settle_clocks_r <= wbyte[`SETTLE_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_mask_r <= {`IRQ_W{1'b0}};
    end else if (wr_mask) begin
      irq_mask_r <= wbyte[`IRQ_W-1:0];
    end
  end

  // Step conditions of the bit search
  wire settle_done = settle_cnt_r <= 4'h1;
  wire trial_due   = wait_cnt_r == 2'h0;
  wire last_bit    = bit_r == 4'h0;

  // Settle, then successive approximation from the top bit
  always_comb begin
    state_nxt      = state_r;
    settle_cnt_nxt = settle_cnt_r;
    sar_nxt        = sar_r;
    bit_nxt        = bit_r;
    wait_cnt_nxt   = wait_cnt_r;
    hold_nxt       = 1'b0;
    start_nxt      = 1'b0;
    done_evt       = 1'b0;
    if (start_req) begin
      state_nxt      = ST_SETTLE;
      settle_cnt_nxt = settle_clocks_r;
      sar_nxt        = '0;
      hold_nxt       = 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          state_nxt = ST_IDLE;
        end
        ST_SETTLE: begin
          if (settle_done) begin
            state_nxt    = ST_CONVERT;
            start_nxt    = 1'b1;
            sar_nxt      = `RES_MSB_TRIAL;
            bit_nxt      = `BIT_IDX_TOP;
            wait_cnt_nxt = `CMP_WAIT;
          end else begin
            hold_nxt       = 1'b1;
            settle_cnt_nxt = settle_cnt_r - 4'h1;
          end
        end
        ST_CONVERT: begin
          if (!trial_due) begin
            wait_cnt_nxt = wait_cnt_r - 2'h1;
          end else begin
            // Keep trial bit while input is above DAC
            if (!cmp_sync) begin
              sar_nxt[bit_r] = 1'b0;
            end
            if (last_bit) begin
              state_nxt = ST_IDLE;
              done_evt  = 1'b1;
            end else begin
              sar_nxt[bit_r - 4'h1] = 1'b1;
              bit_nxt      = bit_r - 4'h1;
              wait_cnt_nxt = `CMP_WAIT;
            end
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle_cnt_r <= {`SETTLE_W{1'b0}};
    end else begin
      settle_cnt_r <= settle_cnt_nxt;
    end
  end

  // Trial code, bit pointer and comparator wait
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sar_r <= '0;
    end else begin
      sar_r <= sar_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_r      <= {`BIT_IDX_W{1'b0}};
      wait_cnt_r <= 2'h0;
    end else begin
      bit_r      <= bit_nxt;
      wait_cnt_r <= wait_cnt_nxt;
    end
  end

  // Analog control pins leave straight from flops
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sample_hold_o <= 1'b0;
    end else begin
      sample_hold_o <= hold_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= start_nxt;
    end
  end

  // Search saturates at all zeros or all ones
  assign dac_code_o             = sar_r;
  assign analog_input_channel_o = chan_r;

  // Result registers
  wire rd_high = rd_acc & hit_high;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result_upper_byte_r <= 8'h00;
    end else if (done_evt) begin
      result_upper_byte_r <= sar_nxt[`RES_W-1:2];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      latest_low_r <= 2'h0;
    end else if (done_evt) begin
      latest_low_r <= sar_nxt[1:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result_lower_bits_r <= 2'h0;
    end else if (rd_high) begin
      result_lower_bits_r <= latest_low_r;
    end
  end

  // Level interrupt from unmasked sticky flags
  wire irq_any = |(irq_status & irq_mask_r);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_any;
    end
  end

endmodule // adc_conversion_control

// ---- core/adc_ctrl_params.svh ----
// Constants of the converter control block: register indices, field
// positions, reset values and conversion timing.
// Assumes a 20 MHz system clock and a byte-addressed 32-bit slave port.
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// Register indices; byte address is four times the index
`define ADC_CTRL_IDX        12'hF70
`define RESULT_HIGH_IDX     12'hF72
`define RESULT_LOW_IDX      12'hF73
`define SETTLE_TIME_IDX     12'hF74
`define IRQ_STATUS_IDX      12'hF78
`define IRQ_MASK_IDX        12'hF79

`define ADDR_W              14
`define DATA_W              32

// Control register fields
`define CTRL_START_BIT      7
`define CHAN_W              3

// Settling field
`define SETTLE_W            4
`define SETTLE_RESET        4'hF

// Result layout
`define RES_W               10
`define RES_MSB_TRIAL       10'h200
`define BIT_IDX_W           4
`define BIT_IDX_TOP         4'h9

// Clocks the comparator needs per trial bit, synchroniser included
`define CMP_WAIT            2'h3

// Interrupt status and mask bits
`define IRQ_W               2
`define IRQ_DONE_BIT        0
`define IRQ_ABORT_BIT       1

`endif

// ---- core/adc_ctrl_pkg.sv ----
// Types shared by the converter control block.
// Assumes adc_ctrl_params.svh for widths.
`include "adc_ctrl_params.svh"

package adc_ctrl_pkg;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SETTLE  = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_t;

  typedef logic [`RES_W-1:0] result_t;

endpackage

// ---- core/sync2.sv ----
// Two-flop synchroniser for a single level from outside the clock domain.
// Assumes the input is a slowly changing level.
`timescale 1ns/100ps

module sync2 (
  input  wire logic clk_i,      // System clock
  input  wire logic reset_n_i,  // Async reset, active low
  input  wire logic d_i,        // Asynchronous level
  output logic      q_o         // Synchronised level
);

  logic meta_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule // sync2

// ---- core/irq_flag.sv ----
// Sticky interrupt flag: hardware sets, software clears by writing one.
// Assumes set and clear are single-cycle pulses on the system clock.
`timescale 1ns/100ps

module irq_flag (
  input  wire logic clk_i,      // System clock
  input  wire logic reset_n_i,  // Async reset, active low
  input  wire logic set_i,      // Event pulse
  input  wire logic clr_i,      // Write-one-to-clear pulse
  output logic      flag_o      // Sticky flag
);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      // Set wins over a clear in the same cycle
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end

endmodule // irq_flag

// ---- bench/adc_ctrl_sva.sv ----
// Port assertions for the converter control block.
// Assumes one clock domain with an async active low reset.
`timescale 1ns/100ps
`include "adc_ctrl_params.svh"
module adc_ctrl_sva (
  input wire logic                  clk_i,
  input wire logic                  reset_n_i,
  input wire logic [`ADDR_W-1:0]    avs_address_i,
  input wire logic                  avs_read_i,
  input wire logic                  avs_write_i,
  input wire logic [`DATA_W-1:0]    avs_writedata_i,
  input wire logic [3:0]            avs_byteenable_i,
  input wire logic [`DATA_W-1:0]    avs_readdata_o,
  input wire logic                  avs_waitrequest_o,
  input wire logic                  sample_hold_o,
  input wire logic                  conv_start_o,
  input wire adc_ctrl_pkg::result_t dac_code_o,
  input wire logic [`CHAN_W-1:0]    analog_input_channel_o,
  input wire logic                  irq_o
);
  logic wr_ctl;
  logic start_wr;
  assign wr_ctl = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
                  && avs_address_i == {`ADC_CTRL_IDX, 2'b00};
  assign start_wr = wr_ctl && avs_writedata_i[`CTRL_START_BIT];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus answer late");
  wait_short_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("bus answer held too long");
  upper_zero_a: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse too long");
  settle_end_a: assert property (conv_start_o
    |-> $fell(sample_hold_o) && dac_code_o == `RES_MSB_TRIAL) else $error("bad start");
  settle_bound_a: assert property ($rose(sample_hold_o)
    |-> ##[1:15] (conv_start_o || start_wr)) else $error("settle too long");
  chan_write_a: assert property (!$stable(analog_input_channel_o) |-> $past(wr_ctl))
    else $error("channel moved without write");
  irq_drop_a: assert property ($fell(irq_o)
    |-> $past(avs_write_i, 2) || $past(avs_write_i, 3)) else $error("irq dropped alone");
  cover property (start_wr);
  cover property (conv_start_o);
  cover property ($rose(irq_o));
endmodule // adc_ctrl_sva

bind adc_conversion_control adc_ctrl_sva adc_ctrl_sva_i (.*);

// ---- bench/analog_front_model.sv ----
// Behavioural analog front end: sample/hold and comparator.
// Assumes the input level is given in ideal result codes.
`timescale 1ns/100ps
module analog_front_model (
  input  wire logic               clk_i,         // System clock
  input  wire logic               sample_hold_i, // Sampling window
  input  wire logic [9:0]         dac_code_i,    // Trial code
  input  wire logic signed [15:0] level_i,       // Input level
  output logic                    cmp_o          // Input at or above trial
);
  logic [9:0] held_r = 10'h000;
  always @(posedge clk_i)
    if (sample_hold_i)
      held_r <= level_i < 0 ? 10'h000 : (level_i > 1023 ? 10'h3FF : level_i[9:0]);
  assign cmp_o = held_r >= dac_code_i;
endmodule // analog_front_model

// ---- bench/testbench.sv ----
// Self-checking bench for the converter control block.
// Assumes the analog front model stands in for the converter core.
`timescale 1ns/100ps
`include "adc_ctrl_params.svh"
module testbench;
  localparam logic [13:0] A_CTL = {`ADC_CTRL_IDX, 2'b00};
  localparam logic [13:0] A_HI  = {`RESULT_HIGH_IDX, 2'b00};
  localparam logic [13:0] A_LO  = {`RESULT_LOW_IDX, 2'b00};
  localparam logic [13:0] A_SET = {`SETTLE_TIME_IDX, 2'b00};
  localparam logic [13:0] A_ST  = {`IRQ_STATUS_IDX, 2'b00};
  localparam logic [13:0] A_MSK = {`IRQ_MASK_IDX, 2'b00};
  logic clk_i = 0, reset_n_i = 0, avs_read_i = 0, avs_write_i = 0, cmp_i;
  logic avs_waitrequest_o, sample_hold_o, conv_start_o, irq_o;
  logic [13:0] avs_address_i = 14'h0000;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic [31:0] seed = 32'hFCAF;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [2:0] analog_input_channel_o;
  logic signed [15:0] level = 16'sh0000;
  adc_ctrl_pkg::result_t dac_code_o;
  int err_total = 0, compares = 0, sh_cnt = 0, settle_seen = -1, n;
  int tab_st[4] = '{0, 15, 2, 1};
  int tab_v[4] = '{-7, 1500, 700, 1023};

  adc_conversion_control adc_conversion_control_i (.clk_i, .reset_n_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .cmp_i, .sample_hold_o, .conv_start_o, .dac_code_o,
    .analog_input_channel_o, .irq_o);
  analog_front_model analog_front_model_i (.clk_i, .sample_hold_i(sample_hold_o),
    .dac_code_i(dac_code_o), .level_i(level), .cmp_o(cmp_i));

  always #25 clk_i = ~clk_i;

  // Settle length seen on the pins, sampled mid-cycle
  always @(negedge clk_i) begin
    if (conv_start_o)
      settle_seen = sh_cnt;
    sh_cnt = sample_hold_o ? sh_cnt + 1 : 0;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic summarize();
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic fail();
    err_total++;
    summarize();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  // One bus cycle; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    if (k >= 20)
      fail();
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic conv(input int st, input int v, input bit ab);
    int e;
    e = v < 0 ? 0 : (v > 1023 ? 1023 : v);
    level <= ab ? 16'sd512 : 16'(v);
    bus(1, A_MSK, {31'h0, !ab});
    bus(1, A_SET, st);
    bus(1, A_CTL, 32'h80 | st & 7);
    if (ab) begin
      repeat (20) @(posedge clk_i);
      level <= 16'(v);
      bus(1, A_CTL, 32'h80 | st & 7);
    end
    bus(0, A_CTL, 0);
    chk(q[7], 1);
    for (n = 0; n < 60 && q[7] !== 1'b0; n++)
      bus(0, A_CTL, 0);
    if (n >= 60)
      fail();
    chk(settle_seen, st < 1 ? 1 : st);
    chk(analog_input_channel_o, st & 7);
    chk(irq_o, !ab);
    bus(0, A_HI, 0);
    chk(q, e >> 2);
    bus(0, A_LO, 0);
    chk(q, (e & 3) << 6);
    bus(0, A_HI, 0);
    chk(q, e >> 2);
    if (ab)
      bus(1, A_MSK, 2);
    bus(0, A_ST, 0);
    chk(q, ab ? 3 : 1);
    chk(irq_o, 1);
    bus(1, A_ST, 3);
    bus(0, A_ST, 0);
    chk(irq_o, 0);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    fail();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    bus(0, A_SET, 0);
    chk(q, 32'h0F);
    bus(0, 14'h0040, 0);
    chk(q, 32'h0);
    bus(1, A_SET, 32'hA5);
    bus(0, A_SET, 0);
    chk(q, 32'h05);
    avs_byteenable_i <= 4'hE;
    bus(1, A_SET, 32'h03);
    avs_byteenable_i <= 4'hF;
    bus(0, A_SET, 0);
    chk(q, 32'h05);
    foreach (tab_st[i])
      conv(tab_st[i], tab_v[i], i == 2);
    conv(10, 333, 0);
    repeat (4)
      conv(rnd() % 16, int'(rnd() % 1200) - 80, 0);
    summarize();
  end
endmodule // testbench
